// ### logic/scc_pkg.sv
// Constants for the sensorless commutation configuration word.
package scc_pkg;
	localparam logic [7:0] SCC_CFG_OFFSET = 8'h8A;
	localparam logic [31:0] SCC_CFG_RESET = 32'h14000000;

	localparam int SCC_PARITY_BIT = 31;
	localparam int SCC_DEMAG_CNT_LSB = 29;
	localparam int SCC_DEMAG_HI_LSB = 27;
	localparam int SCC_DEMAG_LO_LSB = 25;
	localparam int SCC_SMP_ZC_LSB = 23;
	localparam int SCC_SMP_INT_LSB = 21;
	localparam int SCC_DUTY_ZC_LSB = 19;
	localparam int SCC_DUTY_INT_LSB = 17;
	localparam int SCC_FALL_LIM_LSB = 11;
	localparam int SCC_RISE_LIM_LSB = 5;
	localparam int SCC_LIM_CODE_W = 6;

	// Code-to-value tables, entry 0 in the low slot.
	localparam logic [3:0][2:0] SCC_DEMAG_CNT_TBL =
		{3'h5, 3'h4, 3'h3, 3'h2};
	localparam logic [3:0][7:0] SCC_DEMAG_HI_MV_TBL =
		{8'hB4, 8'h96, 8'h78, 8'h5A};
	localparam logic [3:0][7:0] SCC_DEMAG_LO_MV_TBL =
		{8'h78, 8'h5A, 8'h3C, 8'h1E};
	localparam logic [3:0][7:0] SCC_SMP_ZC_TBL =
		{8'h08, 8'h06, 8'h04, 8'h03};
	localparam logic [3:0][7:0] SCC_SMP_INT_TBL =
		{8'h0A, 8'h08, 8'h06, 8'h04};
	localparam logic [3:0][6:0] SCC_DUTY_TBL =
		{7'h14, 7'h12, 7'h0F, 7'h0C};

	// Integration limit decode: knees and step sizes.
	localparam logic [5:0] SCC_LIM_KNEE1 = 6'h20;
	localparam logic [5:0] SCC_LIM_KNEE2 = 6'h30;
	localparam logic [5:0] SCC_LIM_KNEE3 = 6'h38;
	localparam logic [11:0] SCC_LIM_BASE1 = 12'h320;
	localparam logic [11:0] SCC_LIM_BASE2 = 12'h640;
	localparam logic [11:0] SCC_LIM_BASE3 = 12'h960;
	localparam logic [11:0] SCC_LIM_STEP0 = 12'h019;
	localparam logic [11:0] SCC_LIM_STEP1 = 12'h032;
	localparam logic [11:0] SCC_LIM_STEP2 = 12'h064;
	localparam logic [11:0] SCC_LIM_STEP3 = 12'h0C8;

	typedef enum logic {
		SCC_MODE_ZERO_CROSS,
		SCC_MODE_INTEGRATE
	} scc_mode_e;
endpackage : scc_pkg

// ### logic/scc_limit_decode.sv
// Maps a 6-bit integration limit code onto its back-EMF integral value.
module scc_limit_decode
	import scc_pkg::*;
(
	input wire logic [5:0] limitCode,
	output logic [11:0] limitValue
);
	wire logic [11:0] codeWide = {6'h00, limitCode};
	wire logic [11:0] seg0 = 12'(codeWide * SCC_LIM_STEP0);
	wire logic [11:0] seg1 = 12'(SCC_LIM_BASE1
		+ (codeWide - {6'h00, SCC_LIM_KNEE1}) * SCC_LIM_STEP1);
	wire logic [11:0] seg2 = 12'(SCC_LIM_BASE2
		+ (codeWide - {6'h00, SCC_LIM_KNEE2}) * SCC_LIM_STEP2);
	wire logic [11:0] seg3 = 12'(SCC_LIM_BASE3
		+ (codeWide - {6'h00, SCC_LIM_KNEE3}) * SCC_LIM_STEP3);

	// Step widens from 25 to 50, 100 and 200 at each knee.
	assign limitValue = (limitCode <= SCC_LIM_KNEE1) ? seg0 :
		(limitCode <= SCC_LIM_KNEE2) ? seg1 :
		(limitCode <= SCC_LIM_KNEE3) ? seg2 : seg3;
endmodule : scc_limit_decode

// ### logic/scc_config_top.sv
// Commutation configuration word with its decode and method selection.
module scc_config_top
	import scc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [31:0] regWrData,
	output logic [31:0] regRdData,
	input wire logic parityOdd,
	output logic parityErr,
	input wire logic demagSampleValid,
	input wire logic [15:0] phaseMv,
	input wire logic [15:0] supplyMv,
	output logic demagDone,
	input wire logic speedSampleValid,
	input wire logic [7:0] samplesPer30,
	input wire logic [6:0] dutyPct,
	output logic integrateMode,
	input wire logic risingPhase,
	input wire logic [11:0] bemfIntegral,
	output logic integralReached,
	output logic [2:0] demagCount,
	output logic [11:0] fallingLimit,
	output logic [11:0] risingLimit
);
	logic [31:0] cfgWord_q;
	logic [2:0] demagRun_q;
	logic demagDone_q;
	scc_mode_e mode_q;
	logic integralReached_q;
	logic [2:0] demagCount_q;
	logic [11:0] fallingLimit_q;
	logic [11:0] risingLimit_q;
	logic parityErr_q;

	// Only the one word is decoded; writes elsewhere are dropped silently.
	wire logic cfgHit = (regAddr == SCC_CFG_OFFSET);
	wire logic cfgWrite = regWrEn && cfgHit;

	// Field extraction.
	wire logic [1:0] demagCntCode = cfgWord_q[SCC_DEMAG_CNT_LSB +: 2];
	wire logic [1:0] demagHiCode = cfgWord_q[SCC_DEMAG_HI_LSB +: 2];
	wire logic [1:0] demagLoCode = cfgWord_q[SCC_DEMAG_LO_LSB +: 2];
	wire logic [1:0] smpZcCode = cfgWord_q[SCC_SMP_ZC_LSB +: 2];
	wire logic [1:0] smpIntCode = cfgWord_q[SCC_SMP_INT_LSB +: 2];
	wire logic [1:0] dutyZcCode = cfgWord_q[SCC_DUTY_ZC_LSB +: 2];
	wire logic [1:0] dutyIntCode = cfgWord_q[SCC_DUTY_INT_LSB +: 2];
	wire logic [5:0] fallCode =
		cfgWord_q[SCC_FALL_LIM_LSB +: SCC_LIM_CODE_W];
	wire logic [5:0] riseCode =
		cfgWord_q[SCC_RISE_LIM_LSB +: SCC_LIM_CODE_W];

	wire logic [2:0] demagNeed = SCC_DEMAG_CNT_TBL[demagCntCode];
	wire logic [7:0] demagHiMv = SCC_DEMAG_HI_MV_TBL[demagHiCode];
	wire logic [7:0] demagLoMv = SCC_DEMAG_LO_MV_TBL[demagLoCode];
	wire logic [7:0] smpZcLevel = SCC_SMP_ZC_TBL[smpZcCode];
	wire logic [7:0] smpIntLevel = SCC_SMP_INT_TBL[smpIntCode];
	wire logic [6:0] dutyZcLevel = SCC_DUTY_TBL[dutyZcCode];
	wire logic [6:0] dutyIntLevel = SCC_DUTY_TBL[dutyIntCode];

	wire logic [11:0] fallDecoded;
	wire logic [11:0] riseDecoded;

	scc_limit_decode fallDecode (
		.limitCode(fallCode),
		.limitValue(fallDecoded)
	);

	scc_limit_decode riseDecode (
		.limitCode(riseCode),
		.limitValue(riseDecoded)
	);

	// The upper bound sits below the supply; a supply under the offset
	// leaves no window, so the check simply never passes then.
	wire logic [15:0] hiOffset = {8'h00, demagHiMv};
	wire logic supplyAbove = (supplyMv > hiOffset);
	wire logic [15:0] upperMv = supplyAbove ? (supplyMv - hiOffset) : 16'h0000;
	wire logic inWindow = supplyAbove && (phaseMv < upperMv)
		&& (phaseMv > {8'h00, demagLoMv});
	// A run already at or past the need is clamped to it, so lowering
	// the count while a run is in progress cannot wrap the counter.
	wire logic [2:0] demagRun_d = inWindow ?
		((demagRun_q >= demagNeed) ? demagNeed : 3'(demagRun_q + 3'h1)) :
		3'h0;
	wire logic demagDone_d = (demagRun_d == demagNeed);

	// Hysteresis: either quantity falling low drops back to zero-cross;
	// both must be high to enter integration, which keeps it stable.
	wire logic goZeroCross = (samplesPer30 < smpZcLevel)
		|| (dutyPct < dutyZcLevel);
	wire logic goIntegrate = (samplesPer30 > smpIntLevel)
		&& (dutyPct > dutyIntLevel);

	wire logic [11:0] activeLimit = risingPhase ?
		risingLimit_q : fallingLimit_q;
	// The compare uses the registered limits, so a new code takes effect
	// one edge after the decoded limit has settled.
	wire logic reachNow = (mode_q == SCC_MODE_INTEGRATE)
		&& (bemfIntegral >= activeLimit);

	wire logic parityNow = (^cfgWord_q) ^ parityOdd;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgWord_q <= SCC_CFG_RESET;
		end else if (cfgWrite) begin
			cfgWord_q <= regWrData;
		end
	end

	// Run length and verdict only move on a qualified sample, so the
	// verdict stands between samples however far apart they are.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			demagRun_q <= 3'h0;
		end else if (demagSampleValid) begin
			demagRun_q <= demagRun_d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			demagDone_q <= 1'b0;
		end else if (demagSampleValid) begin
			demagDone_q <= demagDone_d;
		end
	end

	// A sample only moves the method when its own switch condition holds.
	scc_mode_e mode_d;

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			SCC_MODE_ZERO_CROSS: begin
				if (speedSampleValid && goIntegrate) begin
					mode_d = SCC_MODE_INTEGRATE;
				end
			end
			SCC_MODE_INTEGRATE: begin
				if (speedSampleValid && goZeroCross) begin
					mode_d = SCC_MODE_ZERO_CROSS;
				end
			end
			default: begin
				mode_d = SCC_MODE_ZERO_CROSS;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= SCC_MODE_ZERO_CROSS;
		end else begin
			mode_q <= mode_d;
		end
	end

	// The decoded count and limits are registered, so they trail a write by one edge.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			demagCount_q <= 3'h0;
		end else begin
			demagCount_q <= demagNeed;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fallingLimit_q <= 12'h000;
		end else begin
			fallingLimit_q <= fallDecoded;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			risingLimit_q <= 12'h000;
		end else begin
			risingLimit_q <= riseDecoded;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			integralReached_q <= 1'b0;
		end else begin
			integralReached_q <= reachNow;
		end
	end

	// Parity is reported only; the word is kept whatever its parity.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			parityErr_q <= 1'b0;
		end else begin
			parityErr_q <= parityNow;
		end
	end

	// Unmapped addresses read as zero.
	assign regRdData = cfgHit ? cfgWord_q : 32'h00000000;
	assign parityErr = parityErr_q;
	assign demagDone = demagDone_q;
	assign integrateMode = (mode_q == SCC_MODE_INTEGRATE);
	assign integralReached = integralReached_q;
	assign demagCount = demagCount_q;
	assign fallingLimit = fallingLimit_q;
	assign risingLimit = risingLimit_q;
endmodule : scc_config_top

// ### sim/scc_config_chk.sv
// Concurrent checks on the commutation configuration block ports.
module scc_config_chk
	import scc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire logic parityOdd,
	input wire logic parityErr,
	input wire logic demagSampleValid,
	input wire logic demagDone,
	input wire logic speedSampleValid,
	input wire logic integrateMode,
	input wire logic risingPhase,
	input wire logic integralReached,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] samplesPer30,
	input wire logic [31:0] regWrData,
	input wire logic [31:0] regRdData,
	input wire logic [15:0] phaseMv,
	input wire logic [15:0] supplyMv,
	input wire logic [6:0] dutyPct,
	input wire logic [11:0] bemfIntegral,
	input wire logic [11:0] fallingLimit,
	input wire logic [11:0] risingLimit,
	input wire logic [2:0] demagCount
);
	logic [31:0] word_q;
	function automatic logic [11:0] lim(logic [5:0] c);
		if (c <= 6'h20) return c * 12'h019;
		if (c <= 6'h30) return 12'h320 + (c - 6'h20) * 12'h032;
		if (c <= 6'h38) return 12'h640 + (c - 6'h30) * 12'h064;
		return 12'h960 + (c - 6'h38) * 12'h0C8;
	endfunction : lim
	// Shadow copy of the word, so decode checks do not depend on reads.
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n) word_q <= SCC_CFG_RESET;
		else if (regWrEn && regAddr == SCC_CFG_OFFSET) word_q <= regWrData;
	wire [2:0] cntExp = 3'h2 + word_q[30:29];
	wire [11:0] fallExp = lim(word_q[16:11]);
	wire [11:0] riseExp = lim(word_q[10:5]);
	wire parExp = ^word_q ^ parityOdd;
	wire [11:0] actLim = risingPhase ? risingLimit : fallingLimit;
	wire reachExp = integrateMode && bemfIntegral >= actLim;
	wire [16:0] topMv = {1'b0, supplyMv} - SCC_DEMAG_HI_MV_TBL[word_q[28:27]];
	wire inWin = phaseMv > SCC_DEMAG_LO_MV_TBL[word_q[26:25]]
		&& {1'b0, phaseMv} < topMv && !topMv[16];
	wire goInt = samplesPer30 > SCC_SMP_INT_TBL[word_q[22:21]]
		&& dutyPct > SCC_DUTY_TBL[word_q[18:17]];
	wire goZc = samplesPer30 < SCC_SMP_ZC_TBL[word_q[24:23]]
		|| dutyPct < SCC_DUTY_TBL[word_q[20:19]];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Mode thresholds decode the word unregistered; mode entry and exit checks still skip a write in this or the last cycle.
	sequence quiet;
		!regWrEn ##1 !regWrEn;
	endsequence
	a_read_word: assert property (regAddr == SCC_CFG_OFFSET |->
		regRdData == word_q) else $error("word readback differs");
	a_read_other: assert property (regAddr != SCC_CFG_OFFSET |->
		regRdData == 32'h0) else $error("unmapped read not zero");
	// Registers still hold their reset value at the first edge after release.
	a_demag_count: assert property (demagCount ==
		($past(rst_n) ? $past(cntExp) : 3'h0))
		else $error("sample count decode wrong");
	a_fall_limit: assert property (fallingLimit ==
		($past(rst_n) ? $past(fallExp) : 12'h000))
		else $error("falling limit decode wrong");
	a_rise_limit: assert property (risingLimit ==
		($past(rst_n) ? $past(riseExp) : 12'h000))
		else $error("rising limit decode wrong");
	a_parity_flag: assert property (parityErr ==
		($past(rst_n) ? $past(parExp) : 1'b0))
		else $error("parity flag wrong");
	a_integral_hit: assert property (integralReached ==
		($past(rst_n) ? $past(reachExp) : 1'b0))
		else $error("integral compare wrong");
	a_mode_enter: assert property (quiet ##0
		(speedSampleValid && !integrateMode && goInt) |=> integrateMode)
		else $error("no entry");
	a_mode_exit: assert property (quiet ##0
		(speedSampleValid && integrateMode && goZc) |=> !integrateMode)
		else $error("no exit");
	a_mode_hold: assert property (!speedSampleValid |=>
		$stable(integrateMode)) else $error("mode moved idle");
	a_demag_reject: assert property (quiet ##0
		(demagSampleValid && !inWin) |=> !demagDone) else $error("bad done");
endmodule : scc_config_chk
bind scc_config_top scc_config_chk chk (.*);

// ### sim/tb_top.sv
// Self-checking bench for the commutation configuration block.
module tb_top
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_n = 0, regWrEn = 0, parityOdd = 0, risingPhase = 0;
	logic demagSampleValid = 0, speedSampleValid = 0;
	logic [7:0] regAddr = 0, samplesPer30 = 0;
	logic [15:0] phaseMv = 0, supplyMv = 16'h2EE0;
	logic [6:0] dutyPct = 0;
	logic [11:0] bemfIntegral = 0, fallingLimit, risingLimit;
	logic [31:0] regWrData = 0, regRdData, w, got, obs[8], expQ[$];
	logic parityErr, demagDone, integrateMode, integralReached;
	logic [2:0] demagCount;
	int failures = 0, checks_done = 0, cycles = 0, n, selQ[$];
	int zcT[4] = '{3, 4, 6, 8}, inT[4] = '{4, 6, 8, 10}, dT[4] = '{12, 15, 18, 20};
	int loT[4] = '{30, 60, 90, 120}, hiT[4] = '{90, 120, 150, 180};
	int bT[6] = '{'h20, 'h32, 'h3F, 'h31, 'h38, 'h39};
	scc_config_top DUT (.*);
	always #2 core_clk = ~core_clk;
	always_comb obs = '{regRdData, demagCount, fallingLimit, risingLimit,
		parityErr, integrateMode, demagDone, integralReached};
	function automatic int lim(int c);
		return c <= 32 ? c * 25 : c <= 48 ? 800 + (c - 32) * 50 :
			c <= 56 ? 1600 + (c - 48) * 100 : 2400 + (c - 56) * 200;
	endfunction : lim
	task cyc;
		@(posedge core_clk);
		#1;
	endtask : cyc
	task note(int s, logic [31:0] v);
		selQ.push_back(s);
		expQ.push_back(v);
	endtask : note
	task complete_run;
		$display("failures %0d checks %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	// A hang would otherwise never reach the verdict.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			complete_run;
		end
	end
	always @(negedge core_clk) while (expQ.size() > 0) begin
		got = obs[selQ.pop_front()];
		checks_done++;
		if (got !== expQ[0]) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, got, expQ[0]);
		end
		void'(expQ.pop_front());
	end
	initial begin
		void'($urandom(32'hC948));
		repeat (2) @(posedge core_clk);
		#1 rst_n = 1;
		regAddr = SCC_CFG_OFFSET;
		note(0, 32'h14000000);
		note(4, ^32'h14000000);
		cyc;
		regAddr = 8'h8B;
		regWrData = 32'hFFFFFFFF;
		regWrEn = 1;
		note(0, 0);
		cyc;
		regWrEn = 0;
		regAddr = SCC_CFG_OFFSET;
		note(0, 32'h14000000);
		for (int i = 0; i < 24; i++) begin
			w = $urandom;
			if (i < 3) w[16:5] = {bT[2 * i][5:0], bT[2 * i + 1][5:0]};
			parityOdd = $urandom % 2;
			regWrData = w;
			regWrEn = 1;
			cyc;
			regWrEn = 0;
			cyc;
			note(0, w);
			note(1, 2 + w[30:29]);
			note(2, lim(w[16:11]));
			note(3, lim(w[10:5]));
			note(4, ^w ^ parityOdd);
			speedSampleValid = 1;
			samplesPer30 = inT[w[22:21]];
			dutyPct = 100;
			cyc;
			note(5, 0);
			samplesPer30 = 200;
			dutyPct = dT[w[18:17]];
			cyc;
			note(5, 0);
			dutyPct++;
			cyc;
			speedSampleValid = 0;
			note(5, 1);
			risingPhase = $urandom % 2;
			n = risingPhase ? lim(w[10:5]) : lim(w[16:11]);
			bemfIntegral = n - $urandom % 2;
			cyc;
			note(7, bemfIntegral >= n);
			speedSampleValid = 1;
			samplesPer30 = zcT[w[24:23]];
			dutyPct = dT[w[20:19]];
			cyc;
			note(5, 1);
			n = $urandom % 2;
			speedSampleValid = 1;
			samplesPer30 = n ? zcT[w[24:23]] - 1 : 200;
			dutyPct = n ? 100 : dT[w[20:19]] - 1;
			cyc;
			speedSampleValid = 0;
			note(5, 0);
			supplyMv = 1000 + $urandom % 30000;
			phaseMv = $urandom % 2 ? loT[w[26:25]] + 1
				: supplyMv - hiT[w[28:27]] - 1;
			demagSampleValid = 1;
			repeat (w[30:29] + 1) cyc;
			note(6, 0);
			cyc;
			note(6, 1);
			phaseMv = $urandom % 2 ? loT[w[26:25]] : supplyMv - hiT[w[28:27]];
			cyc;
			demagSampleValid = 0;
			note(6, 0);
		end
		cyc;
		rst_n = 0;
		cyc;
		rst_n = 1;
		cyc;
		note(0, 32'h14000000);
		note(1, 2);
		note(2, 0);
		note(3, 0);
		note(4, parityOdd);
		note(5, 0);
		cyc;
		complete_run;
	end
endmodule : tb_top
